// ==== rtl/ctc_pkg.sv ====
// Shared constants and types for the CAN transceiver control block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package ctc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    // Dominant timeout; plain default, no figure is given for it
    localparam int DOM_TIMEOUT_US = 1000;
    localparam int CNT_W          = 16;
    // Longest time, so the cycle count rounds down
    localparam logic [CNT_W-1:0] DOM_TIMEOUT_CYC_DEF =
        CNT_W'((DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Pin synchroniser layout
    // ------------------------------------------------------------
    localparam int SYNC_W   = 3;
    localparam int SYNC_TXD = 0;
    localparam int SYNC_BUS = 1;
    localparam int SYNC_DBG = 2;
    // Transmit idles recessive (high), bus idles recessive, no debug
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h1;

    // Cycles after reset release before the debug strap is trusted
    localparam logic [1:0] STRAP_CYC = 2'h3;

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    localparam int TX_WIDTH   = 1;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Transceiver modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_NORMAL        = 2'h1,
        ST_LOW_POWER_OFF = 2'h2
    } ctc_mode_e;

endpackage

// ==== rtl/ctc_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ctc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_i,   // Clock
    input  wire logic             rst_i,       // Sync reset, high
    input  wire logic             flush_i,     // Drop all contents
    input  wire logic             in_valid_i,  // Write request
    output logic                  in_ready_o,  // Not full
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data
    output logic                  out_valid_o, // Not empty
    input  wire logic             out_ready_i, // Read request
    output logic [WIDTH-1:0]      out_data_o   // Head word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // Pointer wrap
    // ------------------------------------------------------------
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Full and empty come straight from the occupancy count
    assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    // Next state of storage and pointers
    always_comb
    begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (flush_i)
        begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next  = '0;
        end
        else
        begin
            if (push)
            begin
                mem_next[wr_ptr_reg] = in_data_i;
                wr_ptr_next          = ptr_inc(wr_ptr_reg);
            end
            if (pop)
            begin
                rd_ptr_next = ptr_inc(rd_ptr_reg);
            end
            if (push && !pop)
            begin
                count_next = count_reg + (PW+1)'(1);
            end
            else if (pop && !push)
            begin
                count_next = count_reg - (PW+1)'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk_i)
    begin
        mem_reg <= mem_next;
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

endmodule

// ==== rtl/ctc_top.sv ====
// Digital control of the high-speed CAN transceiver: drivers, receive
// pin, dominant timeout, low-power-off mode, wake-up and debug strap.
// Assumes the analog front end reports the bus level as a plain pin and
// obeys the driver, bias and pulldown enables given here.
//
// Summary of operation
// - Transmit high: drivers off, bus recessive
// - Transmit low: both drivers on, dominant
// - Dominant too long: drivers forced off
// - Normal: receive pin driven, low dominant
// - Low-power-off: receive pin high impedance
// - Low-power-off: drivers off, pulldowns on
// - Normal recessive: midpoint bias enabled
// - Supply regulator on straight after reset
// - Debug strap forces Normal mode
// - Bus wake-up leaves low-power-off mode
`timescale 1ns/1ps
module ctc_top #(
    parameter logic [ctc_pkg::CNT_W-1:0] DOM_TIMEOUT_CYC = ctc_pkg::DOM_TIMEOUT_CYC_DEF
) (
    input  wire logic ref_clk_i,      // 20 MHz clock
    input  wire logic rst_i,          // Sync reset, high
    input  wire logic txd_i,          // Transmit pin, low = dominant
    input  wire logic bus_dominant_i, // Bus comparator, high = dominant
    input  wire logic debug_i,        // Debug strap pin
    input  wire logic low_power_off_req_i, // Request to enter low-power-off
    input  wire logic can_wake_en_i,  // Bus wake-up allowed
    output logic      rxd_o,          // Receive pin level
    output logic      rxd_oe_o,       // Receive pin driven
    output logic      canh_drv_o,     // High-side driver on
    output logic      canl_drv_o,     // Low-side driver on
    output logic      bias_en_o,      // Midpoint bias on
    output logic      pulldown_en_o,  // Bus input pulldown on
    output logic      reg_en_o,       // Transceiver supply regulator on
    output logic      tx_ready_o,     // Transmit buffer can accept
    output logic      dom_timeout_o,  // Dominant timeout latched
    output logic      low_power_off_mode_o, // In low-power-off mode
    output logic      wake_o          // Wake-up pulse
);
    import ctc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    ctc_mode_e         mode_reg, mode_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [1:0]        strap_cnt_reg, strap_cnt_next;
    logic              debug_reg, debug_next;
    logic              strap_ok_reg, strap_ok_next;
    logic              tx_bit_reg, tx_bit_next;
    logic              lock_reg, lock_next;
    logic              rxd_next, rxd_oe_next, drv_next, bias_next;
    logic              pd_next, reg_en_next, wake_next;
    logic              fifo_valid, fifo_data, pop;
    logic              is_normal;

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    // Drains only in Normal; the pin cannot stall, so a full buffer
    // is reported on tx_ready_o and further samples are dropped.
    ctc_fifo #(
        .WIDTH (TX_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .flush_i     (wake_next),
        .in_valid_i  (1'b1),
        .in_ready_o  (tx_ready_o),
        .in_data_i   (lvl_reg[SYNC_TXD]),
        .out_valid_o (fifo_valid),
        .out_ready_i (is_normal),
        .out_data_o  (fifo_data)
    );

    assign is_normal = (mode_reg == ST_NORMAL);
    assign pop       = is_normal && fifo_valid;
    assign low_power_off_mode_o = (mode_reg == ST_LOW_POWER_OFF);
    assign dom_timeout_o = lock_reg;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Pin levels count only once the second and third stages agree
    always_comb
    begin
        lvl_next = lvl_reg;
        for (int i = 0; i < SYNC_W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                lvl_next[i] = s3_reg[i];
            end
        end

        // Debug strap is caught once, after the synchroniser settles
        strap_cnt_next = strap_cnt_reg;
        strap_ok_next  = strap_ok_reg;
        debug_next     = debug_reg;
        if (!strap_ok_reg)
        begin
            if (strap_cnt_reg == STRAP_CYC)
            begin
                strap_ok_next = 1'b1;
                // The registered level still holds its reset value at this
                // edge, so the strap is taken from the level as it settles
                debug_next    = lvl_next[SYNC_DBG];
            end
            else
            begin
                strap_cnt_next = strap_cnt_reg + 2'h1;
            end
        end

        // Mode: Normal by default; debug strap blocks low-power-off
        mode_next = mode_reg;
        wake_next = 1'b0;
        unique case (mode_reg)
            ST_NORMAL:
            begin
                if (low_power_off_req_i && strap_ok_reg && !debug_reg)
                begin
                    mode_next = ST_LOW_POWER_OFF;
                end
            end
            ST_LOW_POWER_OFF:
            begin
                if (can_wake_en_i && lvl_reg[SYNC_BUS])
                begin
                    mode_next = ST_NORMAL;
                    wake_next = 1'b1;
                end
            end
            default:
            begin
                mode_next = ST_NORMAL;
            end
        endcase

        // Buffered transmit bit; recessive outside Normal
        tx_bit_next = tx_bit_reg;
        if (!is_normal)
        begin
            tx_bit_next = 1'b1;
        end
        else if (pop)
        begin
            tx_bit_next = fifo_data;
        end

        // Dominant timeout: count dominant cycles, clear on recessive
        if (tx_bit_reg)
        begin
            cnt_next  = '0;
            lock_next = 1'b0;
        end
        else
        begin
            cnt_next  = (cnt_reg == DOM_TIMEOUT_CYC) ? cnt_reg : cnt_reg + CNT_W'(1);
            lock_next = lock_reg || (cnt_next == DOM_TIMEOUT_CYC);
        end

        // Drivers follow the transmit bit unless locked or asleep
        drv_next    = is_normal && !tx_bit_reg && !lock_next;
        bias_next   = is_normal;
        pd_next     = !is_normal;
        rxd_next    = !lvl_reg[SYNC_BUS];
        rxd_oe_next = is_normal;
        reg_en_next = is_normal;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // The supply regulator resets on, with no command needed
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s1_reg        <= SYNC_RST;
            s2_reg        <= SYNC_RST;
            s3_reg        <= SYNC_RST;
            lvl_reg       <= SYNC_RST;
            mode_reg      <= ST_NORMAL;
            cnt_reg       <= '0;
            strap_cnt_reg <= '0;
            strap_ok_reg  <= 1'b0;
            debug_reg     <= 1'b0;
            tx_bit_reg    <= 1'b1;
            lock_reg      <= 1'b0;
            rxd_o         <= 1'b1;
            rxd_oe_o      <= 1'b1;
            canh_drv_o    <= 1'b0;
            canl_drv_o    <= 1'b0;
            bias_en_o     <= 1'b1;
            pulldown_en_o <= 1'b0;
            reg_en_o      <= 1'b1;
            wake_o        <= 1'b0;
        end
        else
        begin
            s1_reg        <= {debug_i, bus_dominant_i, txd_i};
            s2_reg        <= s1_reg;
            s3_reg        <= s2_reg;
            lvl_reg       <= lvl_next;
            mode_reg      <= mode_next;
            cnt_reg       <= cnt_next;
            strap_cnt_reg <= strap_cnt_next;
            strap_ok_reg  <= strap_ok_next;
            debug_reg     <= debug_next;
            tx_bit_reg    <= tx_bit_next;
            lock_reg      <= lock_next;
            rxd_o         <= rxd_next;
            rxd_oe_o      <= rxd_oe_next;
            canh_drv_o    <= drv_next;
            canl_drv_o    <= drv_next;
            bias_en_o     <= bias_next;
            pulldown_en_o <= pd_next;
            reg_en_o      <= reg_en_next;
            wake_o        <= wake_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_recessive_off: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (is_normal && tx_bit_reg) |=> (!canh_drv_o && !canl_drv_o))
        else $error("Drivers on while transmit recessive");

    a_dominant_on: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (is_normal && !tx_bit_reg && !lock_next) |=> (canh_drv_o && canl_drv_o))
        else $error("Drivers off while transmit dominant");

    a_timeout_lock: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (cnt_reg == DOM_TIMEOUT_CYC) |-> (lock_reg && !canh_drv_o && !canl_drv_o))
        else $error("Dominant timeout did not release the bus");

    a_rxd_follows: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        is_normal |=> (rxd_oe_o && (rxd_o == !$past(lvl_reg[SYNC_BUS]))))
        else $error("Receive pin does not follow bus");

    a_rxd_float: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        low_power_off_mode_o |=> !rxd_oe_o)
        else $error("Receive pin driven in low-power-off");

    a_off_pulldown: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        low_power_off_mode_o
        |=> (pulldown_en_o && !canh_drv_o && !canl_drv_o && !reg_en_o))
        else $error("Bus not pulled down in low-power-off");

    a_bias_normal: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (is_normal && tx_bit_reg) |=> bias_en_o)
        else $error("Midpoint bias off in Normal recessive");

    a_reg_default: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> reg_en_o)
        else $error("Supply regulator off after reset");

    a_debug_stays: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (debug_reg && is_normal) |=> is_normal)
        else $error("Left Normal mode with debug strap set");

    a_bus_wake: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (low_power_off_mode_o && can_wake_en_i && lvl_reg[SYNC_BUS])
        |=> (is_normal && wake_o))
        else $error("Bus wake-up missed");

    a_unlock_recessive: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(lock_reg) |-> ($past(tx_bit_reg) && (cnt_reg == '0)))
        else $error("Timeout cleared without recessive level");

endmodule

// ==== testbench/ctc_host_model.sv ====
// Host-side CAN protocol controller model: drives the transmit pin and
// samples the receive pin. Assumes the bench calls send() just after a
// rising clock edge.
`timescale 1ns/1ps
module ctc_host_model (
    input  wire logic ref_clk_i, // Clock
    input  wire logic rxd_i,     // Receive pin value
    input  wire logic rxd_oe_i,  // Receive pin driven
    output logic      txd_o,     // Transmit pin, low = dominant
    output logic      rx_bit_o   // Level the host sees on receive
);
    logic last_rx = 1'b1;

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    // Remember the last driven level while the pin is driven
    always @(posedge ref_clk_i)
    begin
        if (rxd_oe_i)
        begin
            last_rx <= rxd_i;
        end
    end
    // Released pin has no pull: show the inverse so a stale copy never passes
    assign rx_bit_o = rxd_oe_i ? rxd_i : ~last_rx;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    initial txd_o = 1'b1;
    // Low sends dominant, high recessive
    task automatic send(input logic b);
        txd_o = b;
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the CAN transceiver control block.
// Assumes a short dominant timeout parameter so the run stays brief.
`timescale 1ns/1ps
module tb;
    import ctc_pkg::*;
    typedef struct {int due; int kind; logic val;} ctc_note_s;
    localparam int K_DRV = 0, K_RXD = 1, K_OE = 2, K_PD = 3, K_BIAS = 4;
    localparam int K_REG = 5, K_TO = 6, K_RDY = 7, K_LP = 8, K_WAKE = 9;

    logic      clk, rst, txd, bus_dom, dbg, off_req, wake_en, rx_bit;
    logic      rxd, rxd_oe, canh, canl, bias, pd, reg_en, rdy, dto, lp, wake;
    int        cyc = 0;
    int        i;
    int        comparisons = 0;
    int        miscompares = 0;
    integer    seed;
    logic      b;
    ctc_note_s notes[$];
    ctc_note_s n;

    // ------------------------------------------------------------
    // Design and host model
    // ------------------------------------------------------------
    ctc_top #(.DOM_TIMEOUT_CYC(16'h10)) ctc_top_i (
        .ref_clk_i(clk), .rst_i(rst), .txd_i(txd), .bus_dominant_i(bus_dom),
        .debug_i(dbg), .low_power_off_req_i(off_req), .can_wake_en_i(wake_en),
        .rxd_o(rxd), .rxd_oe_o(rxd_oe), .canh_drv_o(canh), .canl_drv_o(canl),
        .bias_en_o(bias), .pulldown_en_o(pd), .reg_en_o(reg_en),
        .tx_ready_o(rdy), .dom_timeout_o(dto), .low_power_off_mode_o(lp),
        .wake_o(wake));
    ctc_host_model ctc_host_model_i (
        .ref_clk_i(clk), .rxd_i(rxd), .rxd_oe_i(rxd_oe), .txd_o(txd),
        .rx_bit_o(rx_bit));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Notes and scoreboard
    // ------------------------------------------------------------
    // Sorted insert, since paths of different latency interleave
    task automatic note(input int kind, input int dly, input logic v);
        ctc_note_s m;
        int j;
        m = '{cyc + dly, kind, v};
        j = notes.size();
        while (j > 0 && notes[j-1].due > m.due) j--;
        notes.insert(j, m);
    endtask
    function automatic logic pick(input int k);
        case (k)
            K_DRV:   pick = (canh === canl) ? canh : 1'bx;
            K_RXD:   pick = rx_bit;
            K_OE:    pick = rxd_oe;
            K_PD:    pick = pd;
            K_BIAS:  pick = bias;
            K_REG:   pick = reg_en;
            K_TO:    pick = dto;
            K_RDY:   pick = rdy;
            K_LP:    pick = lp;
            default: pick = wake;
        endcase
    endfunction
    task automatic check(input int kind, input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t kind %0d got %b exp %b", $time, kind, got, exp);
        end
    endtask
    // Outputs settle by the falling edge; due notes are compared there
    always @(negedge clk)
    begin
        while (notes.size() > 0 && notes[0].due <= cyc)
        begin
            n = notes.pop_front();
            check(n.kind, pick(n.kind), n.val);
        end
    end

    // ------------------------------------------------------------
    // Stimulus helpers and closing
    // ------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic d);
        rst = 1'b1;
        dbg = d;
        step(5);
        rst = 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hF2176717;
        {rst, bus_dom, dbg, off_req, wake_en} = 5'h10;
        do_reset(1'b0);
        note(K_REG, 1, 1'b1);
        note(K_OE, 1, 1'b1);
        note(K_BIAS, 1, 1'b1);
        note(K_DRV, 1, 1'b0);
        note(K_PD, 1, 1'b0);
        note(K_RDY, 1, 1'b1);
        step(8);
        $display("test reset done");
        // Random stream; each level stands two cycles, since the pin filter
        // needs two equal samples, and every sixth bit is recessive so that
        // no dominant run reaches the timeout
        for (i = 0; i < 60; i++)
        begin
            b = (i % 6 == 5) ? 1'b1 : 1'($random(seed));
            ctc_host_model_i.send(b);
            bus_dom = 1'($random(seed));
            // Strap and wake enable have no effect in Normal after the strap
            {dbg, wake_en} = 2'($random(seed));
            note(K_DRV, 7, ~b);
            note(K_RXD, 5, ~bus_dom);
            step(2);
        end
        ctc_host_model_i.send(1'b1);
        {bus_dom, dbg, wake_en} = 3'h0;
        step(10);
        $display("test stream done");
        // Stuck dominant, then recessive unlock and a fresh dominant
        ctc_host_model_i.send(1'b0);
        note(K_DRV, 19, 1'b1);
        note(K_DRV, 25, 1'b0);
        note(K_TO, 25, 1'b1);
        step(40);
        ctc_host_model_i.send(1'b1);
        note(K_TO, 10, 1'b0);
        step(12);
        ctc_host_model_i.send(1'b0);
        note(K_DRV, 7, 1'b1);
        step(9);
        ctc_host_model_i.send(1'b1);
        step(10);
        $display("test timeout done");
        // Low-power-off: pins released, buffer fills, bus wake-up
        off_req = 1'b1;
        note(K_LP, 1, 1'b1);
        note(K_OE, 2, 1'b0);
        note(K_PD, 2, 1'b1);
        note(K_BIAS, 2, 1'b0);
        note(K_REG, 2, 1'b0);
        note(K_RDY, 20, 1'b0);
        step(1);
        off_req = 1'b0;
        ctc_host_model_i.send(1'b0);
        note(K_DRV, 15, 1'b0);
        step(20);
        ctc_host_model_i.send(1'b1);
        bus_dom = 1'b1;
        step(10);
        note(K_LP, 1, 1'b1);
        step(2);
        wake_en = 1'b1;
        for (i = 0; i < 12 && wake !== 1'b1; i++) @(negedge clk);
        if (wake !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] %0t no wake-up pulse", $time);
            final_report();
        end
        step(1);
        bus_dom = 1'b0;
        note(K_WAKE, 0, 1'b0);
        note(K_LP, 0, 1'b0);
        note(K_OE, 2, 1'b1);
        note(K_RDY, 3, 1'b1);
        step(10);
        $display("test low power done");
        // Debug strap keeps Normal mode against a random request stream
        do_reset(1'b1);
        step(6);
        for (i = 0; i < 8; i++)
        begin
            off_req = (i == 0) ? 1'b1 : 1'($random(seed));
            note(K_LP, 1, 1'b0);
            note(K_OE, 2, 1'b1);
            step(1);
        end
        off_req = 1'b0;
        ctc_host_model_i.send(1'b0);
        note(K_DRV, 7, 1'b1);
        step(9);
        ctc_host_model_i.send(1'b1);
        step(10);
        $display("test debug done");
        final_report();
    end
endmodule
